// ===== rtl/radio_cfg_pkg.sv
package radio_cfg_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Bus geometry.
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;
	localparam int IDX_W = 6;
	localparam int IDX_LSB = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_SWALLOW = 6'h0f;
	localparam logic [IDX_W-1:0] IDX_MAIN_HI = 6'h10;
	localparam logic [IDX_W-1:0] IDX_MAIN_LO = 6'h11;
	localparam logic [IDX_W-1:0] IDX_REF_HI = 6'h12;
	localparam logic [IDX_W-1:0] IDX_REF_LO = 6'h13;
	localparam logic [IDX_W-1:0] IDX_BIAS = 6'h14;
	localparam logic [IDX_W-1:0] IDX_FEE_CTRL = 6'h15;
	localparam logic [IDX_W-1:0] IDX_FEE_VALUE = 6'h16;
	localparam logic [IDX_W-1:0] IDX_MAIN_MODE = 6'h17;

	////////////////////////////////////////////////////////////////////////////////
	// Field layouts.
	localparam int DIV_W = 12;
	localparam int DIV_HI_W = 4;
	localparam int DIV_LO_W = 8;
	localparam int SWALLOW_W = 6;
	localparam int BIAS_W = 8;
	localparam int FEE_CTRL_W = 3;
	localparam int FEE_CTRL_LSB = 1;
	localparam int FEE_W = 8;
	localparam int MODE_W = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [DIV_HI_W-1:0] RST_DIV_HI = 4'h0;
	localparam logic [DIV_LO_W-1:0] RST_DIV_LO = 8'h00;
	localparam logic [SWALLOW_W-1:0] RST_SWALLOW = 6'h00;
	localparam logic [BIAS_W-1:0] RST_BIAS = 8'hb5;
	localparam logic [FEE_CTRL_W-1:0] RST_FEE_CTRL = 3'h0;
	localparam logic [FEE_W-1:0] RST_FEE = 8'h00;
	localparam logic [MODE_W-1:0] RST_MODE = 2'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Main mode codes.
	localparam logic [MODE_W-1:0] MODE_POWER_DOWN = 2'h0;
	localparam logic [MODE_W-1:0] MODE_STANDBY = 2'h1;
	localparam logic [MODE_W-1:0] MODE_RECEIVE = 2'h2;
	localparam logic [MODE_W-1:0] MODE_TRANSMIT = 2'h3;

	typedef enum logic [1:0] {ST_DOWN, ST_STANDBY, ST_RECEIVE, ST_TRANSMIT} op_state_t;

endpackage

// ===== rtl/mode_state_decoder.sv
`timescale 1ns/1ps
module mode_state_decoder
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Mode code.
	input wire logic [radio_cfg_pkg::MODE_W-1:0] mode_code_i,
	// Section enables.
	output logic xtal_osc_en_o,
	output logic synth_en_o,
	output logic rx_chain_en_o,
	output logic tx_chain_en_o
);
	import radio_cfg_pkg::*;

	op_state_t state;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= ST_DOWN;
		else if (ce_i)
		begin
			unique case (mode_code_i)
				MODE_POWER_DOWN: state <= ST_DOWN;
				MODE_STANDBY: state <= ST_STANDBY;
				MODE_RECEIVE: state <= ST_RECEIVE;
				MODE_TRANSMIT: state <= ST_TRANSMIT;
			endcase
		end
	end

	// The amplifier stage is not among these enables; it is steered elsewhere.
	// Decoding the held state keeps the enables one enabled cycle behind the mode code.
	always_comb
	begin
		xtal_osc_en_o = (state != ST_DOWN);
		synth_en_o = (state == ST_RECEIVE) || (state == ST_TRANSMIT);
		rx_chain_en_o = (state == ST_RECEIVE);
		tx_chain_en_o = (state == ST_TRANSMIT);
	end

endmodule // mode_state_decoder

// ===== rtl/freq_error_capture.sv
`timescale 1ns/1ps
module freq_error_capture
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Estimator result.
	input wire logic sample_i,
	input wire logic [radio_cfg_pkg::FEE_W-1:0] value_i,
	// Held estimate.
	output logic [radio_cfg_pkg::FEE_W-1:0] value_o
);
	import radio_cfg_pkg::*;

	// Holding the value keeps a read stable while the estimator runs on.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			value_o <= RST_FEE;
		else if (ce_i && sample_i)
			value_o <= value_i;
	end

endmodule // freq_error_capture

// ===== rtl/radio_config_register_bank_b.sv
`timescale 1ns/1ps
module radio_config_register_bank_b
(
	// Clock, reset and enable.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [radio_cfg_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [radio_cfg_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [radio_cfg_pkg::DAT_W-1:0] wb_dat_i,
	output logic [radio_cfg_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Frequency error estimator.
	input wire logic fee_sample_i,
	input wire logic [radio_cfg_pkg::FEE_W-1:0] fee_value_i,
	output logic [radio_cfg_pkg::FEE_CTRL_W-1:0] freq_error_ctrl_o,
	// Synthesizer second divider set.
	output logic [radio_cfg_pkg::DIV_W-1:0] second_main_divide_o,
	output logic [radio_cfg_pkg::DIV_W-1:0] second_ref_divide_o,
	output logic [radio_cfg_pkg::SWALLOW_W-1:0] second_swallow_count_o,
	// Fixed bias settings.
	output logic [radio_cfg_pkg::BIAS_W-1:0] fixed_bias_o,
	// Operating state.
	output logic [radio_cfg_pkg::MODE_W-1:0] main_mode_o,
	output logic xtal_osc_en_o,
	output logic synth_en_o,
	output logic rx_chain_en_o,
	output logic tx_chain_en_o
);
	import radio_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Storage.
	logic [DIV_HI_W-1:0] second_main_divide_high;
	logic [DIV_LO_W-1:0] second_main_divide_low;
	logic [DIV_HI_W-1:0] second_ref_divide_high;
	logic [DIV_LO_W-1:0] second_ref_divide_low;
	logic [SWALLOW_W-1:0] second_swallow_count;
	logic [BIAS_W-1:0] fixed_bias_settings;
	logic [FEE_CTRL_W-1:0] freq_error_control;
	logic [FEE_W-1:0] freq_error_estimate;
	logic [MODE_W-1:0] main_mode;
	logic [DAT_W-1:0] next_rdata;
	logic req;
	logic wr_commit;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.
	function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [IDX_W-1:0] idx);
		hit = (adr[ADR_W-1:IDX_LSB] == idx) && (adr[IDX_LSB-1:0] == 2'h0);
	endfunction

	function automatic logic wr_to(input logic commit, input logic [ADR_W-1:0] adr,
		input logic [IDX_W-1:0] idx);
		wr_to = commit && hit(adr, idx);
	endfunction

	assign req = wb_cyc_i && wb_stb_i;

	// A write lands on the edge where the master sees ack, so it is taken exactly once.
	assign wr_commit = ce_i && req && wb_we_i && wb_ack_o && wb_sel_i[0];

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake: ack one cycle after the request, dropped the cycle after.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else if (ce_i)
			wb_ack_o <= req && !wb_ack_o;
	end

	always_comb
	begin
		next_rdata = '0;
		if (hit(wb_adr_i, IDX_SWALLOW))
			next_rdata[SWALLOW_W-1:0] = second_swallow_count;
		if (hit(wb_adr_i, IDX_MAIN_HI))
			next_rdata[DIV_HI_W-1:0] = second_main_divide_high;
		if (hit(wb_adr_i, IDX_MAIN_LO))
			next_rdata[DIV_LO_W-1:0] = second_main_divide_low;
		if (hit(wb_adr_i, IDX_REF_HI))
			next_rdata[DIV_HI_W-1:0] = second_ref_divide_high;
		if (hit(wb_adr_i, IDX_REF_LO))
			next_rdata[DIV_LO_W-1:0] = second_ref_divide_low;
		if (hit(wb_adr_i, IDX_BIAS))
			next_rdata[BIAS_W-1:0] = fixed_bias_settings;
		if (hit(wb_adr_i, IDX_FEE_CTRL))
			next_rdata[FEE_CTRL_LSB+FEE_CTRL_W-1:FEE_CTRL_LSB] = freq_error_control;
		if (hit(wb_adr_i, IDX_FEE_VALUE))
			next_rdata[FEE_W-1:0] = freq_error_estimate;
		if (hit(wb_adr_i, IDX_MAIN_MODE))
			next_rdata[MODE_W-1:0] = main_mode;
	end

	// Unmapped addresses answer with zero; unused bits always read zero.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= '0;
		else if (ce_i && req && !wb_ack_o)
			wb_dat_o <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Divider registers.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			second_swallow_count <= RST_SWALLOW;
		else if (wr_to(wr_commit, wb_adr_i, IDX_SWALLOW))
			second_swallow_count <= wb_dat_i[SWALLOW_W-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			second_main_divide_high <= RST_DIV_HI;
		else if (wr_to(wr_commit, wb_adr_i, IDX_MAIN_HI))
			second_main_divide_high <= wb_dat_i[DIV_HI_W-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			second_main_divide_low <= RST_DIV_LO;
		else if (wr_to(wr_commit, wb_adr_i, IDX_MAIN_LO))
			second_main_divide_low <= wb_dat_i[DIV_LO_W-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			second_ref_divide_high <= RST_DIV_HI;
		else if (wr_to(wr_commit, wb_adr_i, IDX_REF_HI))
			second_ref_divide_high <= wb_dat_i[DIV_HI_W-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			second_ref_divide_low <= RST_DIV_LO;
		else if (wr_to(wr_commit, wb_adr_i, IDX_REF_LO))
			second_ref_divide_low <= wb_dat_i[DIV_LO_W-1:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bias, estimator control and mode registers.
	// Reset puts the bias word at its only legal value, so a host that never writes it is still safe.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fixed_bias_settings <= RST_BIAS;
		else if (wr_to(wr_commit, wb_adr_i, IDX_BIAS))
			fixed_bias_settings <= wb_dat_i[BIAS_W-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			freq_error_control <= RST_FEE_CTRL;
		else if (wr_to(wr_commit, wb_adr_i, IDX_FEE_CTRL))
			freq_error_control <= wb_dat_i[FEE_CTRL_LSB+FEE_CTRL_W-1:FEE_CTRL_LSB];
	end

	// Power down only gates the sections; register contents are kept.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			main_mode <= RST_MODE;
		else if (wr_to(wr_commit, wb_adr_i, IDX_MAIN_MODE))
			main_mode <= wb_dat_i[MODE_W-1:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs and children.
	assign second_main_divide_o = {second_main_divide_high, second_main_divide_low};
	assign second_ref_divide_o = {second_ref_divide_high, second_ref_divide_low};
	assign second_swallow_count_o = second_swallow_count;
	assign fixed_bias_o = fixed_bias_settings;
	assign freq_error_ctrl_o = freq_error_control;
	assign main_mode_o = main_mode;

	mode_state_decoder u_mode
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.mode_code_i(main_mode),
		.xtal_osc_en_o(xtal_osc_en_o),
		.synth_en_o(synth_en_o),
		.rx_chain_en_o(rx_chain_en_o),
		.tx_chain_en_o(tx_chain_en_o)
	);

	freq_error_capture u_fee
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.sample_i(fee_sample_i),
		.value_i(fee_value_i),
		.value_o(freq_error_estimate)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_MODE_POWER_DOWN: assert property (
		(ce_i && main_mode == MODE_POWER_DOWN)
		|=> (!xtal_osc_en_o && !synth_en_o && !rx_chain_en_o && !tx_chain_en_o))
	else $error("power down left a section enabled");

	AST_MODE_STANDBY: assert property (
		(ce_i && main_mode == MODE_STANDBY)
		|=> (xtal_osc_en_o && !synth_en_o && !rx_chain_en_o && !tx_chain_en_o))
	else $error("standby enables are wrong");

	AST_MODE_RX_TX: assert property (
		(ce_i && main_mode[1])
		|=> (xtal_osc_en_o && synth_en_o && (rx_chain_en_o != tx_chain_en_o)
		&& (tx_chain_en_o == $past(main_mode[0]))))
	else $error("receive or transmit enables are wrong");

	AST_MAIN_DIV_HI: assert property (
		wr_to(wr_commit, wb_adr_i, IDX_MAIN_HI)
		|=> (second_main_divide_o[DIV_W-1:DIV_LO_W] == $past(wb_dat_i[DIV_HI_W-1:0])))
	else $error("main divide high nibble not stored");

	AST_MAIN_DIV_LO: assert property (
		wr_to(wr_commit, wb_adr_i, IDX_MAIN_LO)
		|=> (second_main_divide_o[DIV_LO_W-1:0] == $past(wb_dat_i[DIV_LO_W-1:0])))
	else $error("main divide low byte not stored");

	AST_REF_DIV: assert property (
		wr_to(wr_commit, wb_adr_i, IDX_REF_HI)
		|=> (second_ref_divide_o[DIV_W-1:DIV_LO_W] == $past(wb_dat_i[DIV_HI_W-1:0]))
		&& $stable(second_ref_divide_o[DIV_LO_W-1:0]))
	else $error("reference divide high write wrong");

	AST_SWALLOW: assert property (
		wr_to(wr_commit, wb_adr_i, IDX_SWALLOW)
		|=> (second_swallow_count_o == $past(wb_dat_i[SWALLOW_W-1:0])))
	else $error("swallow count not stored");

	AST_FEE_CTRL: assert property (
		wr_to(wr_commit, wb_adr_i, IDX_FEE_CTRL)
		|=> (freq_error_ctrl_o == $past(wb_dat_i[FEE_CTRL_LSB+FEE_CTRL_W-1:FEE_CTRL_LSB])))
	else $error("estimator control bits misplaced");

	AST_FEE_READ: assert property (
		(ce_i && req && !wb_ack_o && !wb_we_i && hit(wb_adr_i, IDX_FEE_VALUE))
		|=> (wb_ack_o && wb_dat_o == {{(DAT_W-FEE_W){1'b0}}, $past(freq_error_estimate)}))
	else $error("estimate read back wrong");

	AST_HI_READ_UNUSED_ZERO: assert property (
		(wb_ack_o && hit(wb_adr_i, IDX_MAIN_HI)) |-> (wb_dat_o[DAT_W-1:DIV_HI_W] == '0))
	else $error("unused bits of main divide high read nonzero");

	AST_ACK_PULSE: assert property (
		(ce_i && wb_ack_o) |=> !wb_ack_o)
	else $error("ack held longer than one cycle");

	AST_ACK_ANSWERS: assert property (
		(ce_i && req && !wb_ack_o) |=> wb_ack_o)
	else $error("request left without ack");

	AST_ACK_NEEDS_REQUEST: assert property (
		(ce_i && !req) |=> !wb_ack_o)
	else $error("ack without a request");

	AST_MAIN_HI_READ: assert property (
		(ce_i && req && !wb_ack_o && !wb_we_i && hit(wb_adr_i, IDX_MAIN_HI))
		|=> (wb_dat_o[DIV_HI_W-1:0] == $past(second_main_divide_o[DIV_W-1:DIV_LO_W])))
	else $error("main divide high nibble read back wrong");

	AST_REF_DIV_LO: assert property (
		wr_to(wr_commit, wb_adr_i, IDX_REF_LO)
		|=> (second_ref_divide_o[DIV_LO_W-1:0] == $past(wb_dat_i[DIV_LO_W-1:0]))
		&& $stable(second_ref_divide_o[DIV_W-1:DIV_LO_W]))
	else $error("reference divide low write wrong");

	AST_REF_HI_READ_UNUSED_ZERO: assert property (
		(wb_ack_o && hit(wb_adr_i, IDX_REF_HI)) |-> (wb_dat_o[DAT_W-1:DIV_HI_W] == '0))
	else $error("unused bits of reference divide high read nonzero");

	AST_SWALLOW_READ_UNUSED_ZERO: assert property (
		(wb_ack_o && hit(wb_adr_i, IDX_SWALLOW)) |-> (wb_dat_o[DAT_W-1:SWALLOW_W] == '0))
	else $error("unused bits of swallow count read nonzero");

	AST_FEE_CTRL_READ_UNUSED_ZERO: assert property (
		(wb_ack_o && hit(wb_adr_i, IDX_FEE_CTRL))
		|-> (wb_dat_o[DAT_W-1:FEE_CTRL_LSB+FEE_CTRL_W] == '0) && (wb_dat_o[FEE_CTRL_LSB-1:0] == '0))
	else $error("unused bits of estimator control read nonzero");

	AST_FEE_CAPTURE: assert property (
		(ce_i && fee_sample_i) |=> (freq_error_estimate == $past(fee_value_i)))
	else $error("estimate not captured");

	AST_FEE_VALUE_READ_ONLY: assert property (
		(wr_to(wr_commit, wb_adr_i, IDX_FEE_VALUE) && !fee_sample_i) |=> $stable(freq_error_estimate))
	else $error("write reached the read-only estimate");

	AST_MODE_STORE: assert property (
		wr_to(wr_commit, wb_adr_i, IDX_MAIN_MODE) |=> (main_mode_o == $past(wb_dat_i[MODE_W-1:0])))
	else $error("mode code not stored");

	AST_BIAS_STORE: assert property (
		wr_to(wr_commit, wb_adr_i, IDX_BIAS) |=> (fixed_bias_o == $past(wb_dat_i[BIAS_W-1:0])))
	else $error("bias word not stored as written");

	// A frozen cycle must leave every register and the bus answer exactly as it was.
	AST_CE_FREEZE: assert property (
		!ce_i |=> $stable({wb_ack_o, wb_dat_o, second_main_divide_o, second_ref_divide_o,
		second_swallow_count_o, fixed_bias_o, freq_error_ctrl_o, freq_error_estimate, main_mode_o,
		xtal_osc_en_o, synth_en_o, rx_chain_en_o, tx_chain_en_o}))
	else $error("state moved while the clock enable was low");

	// Nonzero low address bits make every hit fail, so a misaligned write must land nowhere.
	AST_MISALIGNED_WRITE_IGNORED: assert property (
		(wr_commit && wb_adr_i[IDX_LSB-1:0] != '0)
		|=> $stable({second_main_divide_o, second_ref_divide_o, second_swallow_count_o, fixed_bias_o,
		freq_error_ctrl_o, main_mode_o}))
	else $error("misaligned write changed a register");

	AST_MISALIGNED_READ_ZERO: assert property (
		(ce_i && req && !wb_ack_o && wb_adr_i[IDX_LSB-1:0] != '0) |=> (wb_dat_o == '0))
	else $error("misaligned read returned data");

endmodule // radio_config_register_bank_b

// ===== testbench/host_model.sv
`timescale 1ns/1ps
module host_model
(
	// Clock.
	input wire logic clk_i,
	// Bus toward the register bank.
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	input wire logic [31:0] dat_i,
	input wire logic ack_i
);
	initial
	begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One classic cycle; a dead slave is caught by the bench's cycle ceiling, not here.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hf;
		dat_o <= {24'h0, d};
		do
		begin
			@(posedge clk_i);
		end
		while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		dat_o <= ~{24'h0, d};
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// The bias register only ever receives its fixed pattern.
	task automatic put_bias();
		logic [31:0] q;
		xfer(1'b1, 8'h50, {1'b1, 2'b01, 2'b10, 3'b101}, q);
	endtask
endmodule // host_model

// ===== testbench/test_radio_config_register_bank_b.sv
`timescale 1ns/1ps
module test_radio_config_register_bank_b;
	import radio_cfg_pkg::*;
	logic clk_i, rst_i, ce_i, cyc, stb, we, ack, fee_sample;
	logic [7:0] adr, fee_value, fixed_bias, v;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic [2:0] fee_ctrl, c;
	logic [11:0] main_div, ref_div, mv, rv;
	logic [5:0] swallow, sv;
	logic [1:0] main_mode, m;
	logic xtal_en, synth_en, rx_en, tx_en;
	int err_total, check_count, cycles;
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	host_model host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.dat_o(wdat), .dat_i(rdat), .ack_i(ack));
	radio_config_register_bank_b dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .fee_sample_i(fee_sample), .fee_value_i(fee_value), .freq_error_ctrl_o(fee_ctrl),
		.second_main_divide_o(main_div), .second_ref_divide_o(ref_div), .second_swallow_count_o(swallow),
		.fixed_bias_o(fixed_bias), .main_mode_o(main_mode), .xtal_osc_en_o(xtal_en), .synth_en_o(synth_en),
		.rx_chain_en_o(rx_en), .tx_chain_en_o(tx_en));
	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [31:0] r;
		host.xfer(1'b1, {idx, 2'b00}, d, r);
	endtask
	task automatic rd(input logic [5:0] idx, output logic [31:0] r);
		host.xfer(1'b0, {idx, 2'b00}, 8'h00, r);
	endtask
	// Enables in the order crystal, synthesizer, receive, transmit.
	function automatic logic [3:0] exp_en(input logic [1:0] mode);
		case (mode)
			2'h0: return 4'b0000;
			2'h1: return 4'b1000;
			2'h2: return 4'b1110;
			default: return 4'b1101;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// A hang ends in the same report as a normal run.
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_total++;
			summarize();
		end
	end
	initial
	begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		fee_sample = 1'b0;
		fee_value = 8'h00;
		void'($urandom(32'h174b));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("bias_reset", 32'(fixed_bias), 32'(RST_BIAS));
		chk("enables_reset", 32'({xtal_en, synth_en, rx_en, tx_en}), 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			mv = 12'($urandom);
			rv = 12'($urandom);
			sv = 6'($urandom);
			if (i == 3)
			begin
				mv = 12'hfff;
				rv = 12'h801;
				sv = 6'h3f;
			end
			wr(IDX_MAIN_HI, {4'h0, mv[11:8]});
			wr(IDX_MAIN_LO, mv[7:0]);
			wr(IDX_REF_HI, {4'h0, rv[11:8]});
			wr(IDX_REF_LO, rv[7:0]);
			wr(IDX_SWALLOW, {2'b00, sv});
			@(negedge clk_i);
			chk("main_divide", 32'(main_div), 32'(mv));
			chk("ref_divide", 32'(ref_div), 32'(rv));
			chk("swallow", 32'(swallow), 32'(sv));
			rd(IDX_MAIN_HI, q);
			chk("main_hi_read", q, 32'(mv[11:8]));
			rd(IDX_REF_LO, q);
			chk("ref_lo_read", q, 32'(rv[7:0]));
			rd(IDX_MAIN_LO, q);
			chk("main_lo_read", q, 32'(mv[7:0]));
			rd(IDX_REF_HI, q);
			chk("ref_hi_read", q, 32'(rv[11:8]));
			rd(IDX_SWALLOW, q);
			chk("swallow_read", q, 32'(sv));
			c = 3'($urandom);
			wr(IDX_FEE_CTRL, {4'h0, c, 1'b0});
			@(negedge clk_i);
			chk("fee_ctrl", 32'(fee_ctrl), 32'(c));
			rd(IDX_FEE_CTRL, q);
			chk("fee_ctrl_read", q, 32'({c, 1'b0}));
			v = (i == 3) ? 8'h80 : 8'($urandom);
			@(posedge clk_i);
			fee_value <= v;
			fee_sample <= 1'b1;
			@(posedge clk_i);
			fee_sample <= 1'b0;
			wr(IDX_FEE_VALUE, ~v);
			rd(IDX_FEE_VALUE, q);
			chk("estimate", q, 32'(v));
		end
		// A low clock enable must freeze a pending write and a capture strobe alike.
		@(posedge clk_i);
		ce_i <= 1'b0;
		fee_value <= ~v;
		fee_sample <= 1'b1;
		fork
			wr(IDX_SWALLOW, 8'h15);
			begin
				repeat (3) @(posedge clk_i);
				@(negedge clk_i);
				chk("swallow_frozen", 32'(swallow), 32'(sv));
				@(posedge clk_i);
				ce_i <= 1'b1;
				fee_sample <= 1'b0;
			end
		join
		rd(IDX_SWALLOW, q);
		chk("swallow_after_freeze", q, 32'h15);
		rd(IDX_FEE_VALUE, q);
		chk("estimate_frozen", q, 32'(v));
		for (int j = 0; j < 4; j++)
		begin
			m = 2'(3 - j);
			wr(IDX_MAIN_MODE, {6'h00, m});
			repeat (2) @(negedge clk_i);
			chk("mode", 32'(main_mode), 32'(m));
			chk("enables", 32'({xtal_en, synth_en, rx_en, tx_en}), 32'(exp_en(m)));
		end
		host.xfer(1'b1, 8'h00, 8'h5a, q);
		host.xfer(1'b0, 8'h00, 8'h00, q);
		chk("unmapped_read", q, 32'h0);
		host.xfer(1'b0, 8'h41, 8'h00, q);
		chk("misaligned_read", q, 32'h0);
		host.xfer(1'b1, 8'h41, 8'h05, q);
		rd(IDX_MAIN_HI, q);
		chk("misaligned_write", q, 32'(mv[11:8]));
		host.put_bias();
		rd(IDX_BIAS, q);
		chk("bias_read", q, 32'h0000_00b5);
		// A second reset in mid-run must bring the dividers and the estimate back, the mode included.
		wr(IDX_MAIN_MODE, 8'h03);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("divides_after_reset", 32'({main_div, ref_div, swallow}), 32'h0);
		chk("mode_after_reset", 32'({main_mode, xtal_en, synth_en, rx_en, tx_en}), 32'h0);
		rd(IDX_FEE_VALUE, q);
		chk("estimate_after_reset", q, 32'(RST_FEE));
		summarize();
	end
endmodule // test_radio_config_register_bank_b
